// file: rtl/pwrc_pkg.sv
// Purpose: Shared constants and carriers for the pin and watchdog reset control.
// Assumes: One 50 MHz system clock; all timing counted in its cycles.
// Notes: Long counts are also top-level parameters so simulation can shorten them.
package pwrc_pkg;

    localparam int unsigned CLK_HZ = 50_000_000;

    // Oscillation stabilization wait in microseconds, and its cycle count.
    localparam int unsigned OSC_STAB_US = 1311;
    localparam int unsigned OSC_STAB_CYC = (OSC_STAB_US * (CLK_HZ / 1_000_000));

    // Fixed length of the self-timed watchdog reset, in nanoseconds.
    localparam int unsigned WDT_RST_NS = 2000;
    localparam int unsigned WDT_RST_CYC = (WDT_RST_NS + 19) / 20;

    localparam int unsigned CNT_W = 24;

    // CPU clock divider selection after reset: one eighth of the system clock.
    localparam logic [2:0] CPU_DIV_RESET = 3'h3;

    // Debug mode select register value after a pin reset.
    localparam logic [7:0] DBG_MODE_RESET = 8'h01;
    localparam int unsigned DBG_EN_BIT = 0;

    // Reset cause flag layout.
    localparam logic [7:0] CAUSE_RESET = 8'h00;
    localparam int unsigned WDT_CAUSE_BIT = 4;

    // Retention window of internal RAM used by boot firmware.
    localparam logic [27:0] BOOT_RAM_LO = 28'h3ffd000;
    localparam logic [27:0] BOOT_RAM_HI = 28'h3ffd095;

    typedef enum logic [1:0] {
        PWRC_ST_PIN_RST = 2'b00,
        PWRC_ST_WDT_RST = 2'b01,
        PWRC_ST_OSC_WAIT = 2'b10,
        PWRC_ST_RUN = 2'b11
    } pwrc_state_t;

    // Controls handed to the clock generator, CPU and peripherals.
    typedef struct packed {
        logic main_osc_en;
        logic int_osc_en;
        logic periph_clk_en;
        logic cpu_core_clock_en;
        logic [2:0] cpu_div_sel;
        logic cpu_reset;
        logic periph_reset;
        logic watchdog_unit_clear;
        logic pins_hiz;
    } pwrc_ctrl_t;

    // Status of internal RAM seen by the memory controller.
    typedef struct packed {
        logic ram_undefined;
        logic boot_area_lost;
    } pwrc_ram_t;

endpackage

// file: rtl/pwrc_reset_ctrl.sv
// Purpose: Reset sequencer for the external reset pin and watchdog overflow.
// Assumes: Pin inputs are asynchronous; watchdog request is on i_clk_sys.
// Notes: Power-on, low-voltage and clock-monitor resets are handled elsewhere.
`timescale 1ns/1ps

// Overview of operation
// [R1] Low reset pin holds whole system in reset, every unit initialized.
// [R2] Reset pin rising from low to high releases the reset state.
// [R3] System and CPU clocks start after stabilization, divider at system/8.
// [R4] CPU held initialized; executes only after stabilization time elapses.
// [R5] Watchdog counter stopped and zeroed in reset, restarts after release.
// [R6] RAM undefined on power-on reset or CPU access colliding with reset.
// [R7] Otherwise RAM keeps the value held when reset was asserted.
// [R8] Pin reset initializes peripherals and loads debug mode register with 01H.
// [R9] Watchdog reset initializes peripherals but keeps debug mode register.
// [R10] After release, debug pin high with enable bit set enters debug mode.
// [R11] Watchdog overflow in reset mode triggers a full system reset.
// [R12] Watchdog reset lasts a fixed interval then releases by itself.
// [R13] Main oscillator stays stopped during watchdog reset, restarts after.
// [R14] Other peripherals stopped in reset, start only after stabilization.
// [R15] Boot firmware RAM area is not retained across power-on reset.
// [R16] Pin reset clears all cause flags; watchdog reset sets its flag only.
// [R17] Software writes only zero to cause flags; a coincident set wins.
module pwrc_reset_ctrl #(
    parameter int unsigned OSC_STAB_CYCLES = pwrc_pkg::OSC_STAB_CYC
) (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // External pins.
    input wire logic i_reset_pin_n,
    input wire logic i_debug_reset_pin,
    input wire logic i_power_on,
    // Watchdog.
    input wire logic i_watchdog_reset_request,
    input wire logic i_watchdog_reset_mode,
    // CPU and RAM.
    input wire logic i_cpu_ram_access,
    // Software access to the cause flags and debug register.
    input wire logic i_cause_wr,
    input wire logic [7:0] i_cause_wdata,
    input wire logic i_dbg_wr,
    input wire logic [7:0] i_dbg_wdata,
    // Outputs.
    output pwrc_pkg::pwrc_ctrl_t o_ctrl,
    output pwrc_pkg::pwrc_ram_t o_ram,
    output logic [7:0] o_reset_cause_flags,
    output logic [7:0] o_debug_mode_select_reg,
    output logic o_debug_mode_active,
    output logic o_system_reset
);

    localparam logic [pwrc_pkg::CNT_W-1:0] STAB_LAST =
        pwrc_pkg::CNT_W'(OSC_STAB_CYCLES - 1);
    localparam logic [pwrc_pkg::CNT_W-1:0] WDT_LAST =
        pwrc_pkg::CNT_W'(pwrc_pkg::WDT_RST_CYC - 1);

    // Two-stage synchronisers for the pins.
    logic [1:0] rst_sync_r, rst_sync_nxt;
    logic [1:0] debug_reset_pin_sync_r, debug_reset_pin_sync_nxt;
    logic [1:0] por_sync_r, por_sync_nxt;
    logic pin_low;

    always_comb begin
        rst_sync_nxt = {rst_sync_r[0], i_reset_pin_n};
        debug_reset_pin_sync_nxt = {debug_reset_pin_sync_r[0], i_debug_reset_pin};
        por_sync_nxt = {por_sync_r[0], i_power_on};
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_r <= 2'h0;
            debug_reset_pin_sync_r <= 2'h0;
            por_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= rst_sync_nxt;
            debug_reset_pin_sync_r <= debug_reset_pin_sync_nxt;
            por_sync_r <= por_sync_nxt;
        end
    end

    assign pin_low = !rst_sync_r[1];

    // Sequencer state.
    pwrc_pkg::pwrc_state_t state_r, state_nxt;
    logic [pwrc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic wdt_trig;

    assign wdt_trig = i_watchdog_reset_request && i_watchdog_reset_mode;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        if (pin_low) begin
            state_nxt = pwrc_pkg::PWRC_ST_PIN_RST; // [R1]
            cnt_nxt = '0;
        end else begin
            unique case (state_r)
                pwrc_pkg::PWRC_ST_PIN_RST: begin
                    state_nxt = pwrc_pkg::PWRC_ST_OSC_WAIT; // [R2]
                    cnt_nxt = '0;
                end
                pwrc_pkg::PWRC_ST_WDT_RST: begin
                    if (cnt_r == WDT_LAST) begin
                        state_nxt = pwrc_pkg::PWRC_ST_OSC_WAIT; // [R12]
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
                pwrc_pkg::PWRC_ST_OSC_WAIT: begin
                    if (cnt_r == STAB_LAST) begin
                        state_nxt = pwrc_pkg::PWRC_ST_RUN; // [R3] [R4]
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
                pwrc_pkg::PWRC_ST_RUN: begin
                    if (wdt_trig) begin
                        state_nxt = pwrc_pkg::PWRC_ST_WDT_RST; // [R11]
                        cnt_nxt = '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= pwrc_pkg::PWRC_ST_PIN_RST;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Outputs for clock, CPU and peripheral control.
    pwrc_pkg::pwrc_ctrl_t ctrl_r, ctrl_nxt;
    logic sys_rst_r, sys_rst_nxt;
    logic in_reset_nxt;

    always_comb begin
        in_reset_nxt = (state_nxt == pwrc_pkg::PWRC_ST_PIN_RST) ||
                       (state_nxt == pwrc_pkg::PWRC_ST_WDT_RST);
        sys_rst_nxt = in_reset_nxt; // [R1] [R11]
        // Oscillators stop in either reset and start at release.
        ctrl_nxt.main_osc_en = !in_reset_nxt; // [R13]
        ctrl_nxt.int_osc_en = !in_reset_nxt;
        ctrl_nxt.periph_clk_en = (state_nxt == pwrc_pkg::PWRC_ST_RUN); // [R14]
        ctrl_nxt.cpu_core_clock_en =
            (state_nxt == pwrc_pkg::PWRC_ST_RUN); // [R3]
        // The divider is forced to one eighth in every state, including run, so the
        // first instructions always execute at the safe slow rate.
        ctrl_nxt.cpu_div_sel = pwrc_pkg::CPU_DIV_RESET; // [R3]
        ctrl_nxt.cpu_reset = (state_nxt != pwrc_pkg::PWRC_ST_RUN); // [R4]
        ctrl_nxt.periph_reset = in_reset_nxt; // [R8] [R9]
        ctrl_nxt.watchdog_unit_clear = in_reset_nxt; // [R5]
        ctrl_nxt.pins_hiz = in_reset_nxt;
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            sys_rst_r <= 1'b1;
            ctrl_r <= '{main_osc_en: 1'b0, int_osc_en: 1'b0,
                        periph_clk_en: 1'b0, cpu_core_clock_en: 1'b0,
                        cpu_div_sel: pwrc_pkg::CPU_DIV_RESET,
                        cpu_reset: 1'b1, periph_reset: 1'b1,
                        watchdog_unit_clear: 1'b1, pins_hiz: 1'b1};
        end else begin
            sys_rst_r <= sys_rst_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    // RAM state: damaged on power-on or a collision, else retained.
    pwrc_pkg::pwrc_ram_t ram_r, ram_nxt;
    logic reset_entry;

    assign reset_entry = !sys_rst_r && sys_rst_nxt;

    always_comb begin
        ram_nxt = ram_r;
        if (por_sync_r[1]) begin
            ram_nxt.ram_undefined = 1'b1; // [R6]
            ram_nxt.boot_area_lost = 1'b1; // [R15]
        end else if (reset_entry) begin
            ram_nxt.ram_undefined = i_cpu_ram_access; // [R6] [R7]
            ram_nxt.boot_area_lost = 1'b0;
        end else if (i_cause_wr || i_dbg_wr) begin
            // Any cause or debug register write, even during reset, acknowledges the status.
            ram_nxt = '0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ram_r <= '0;
        end else begin
            ram_r <= ram_nxt;
        end
    end

    // Reset cause flags and debug mode register.
    logic [7:0] cause_r, cause_nxt;
    logic [7:0] dbg_r, dbg_nxt;
    logic dbg_act_r, dbg_act_nxt;
    logic wdt_entry;
    logic release_now;

    assign wdt_entry = (state_r == pwrc_pkg::PWRC_ST_RUN) && wdt_trig &&
                       !pin_low;
    assign release_now = (state_r != pwrc_pkg::PWRC_ST_OSC_WAIT) &&
                         (state_nxt == pwrc_pkg::PWRC_ST_OSC_WAIT);

    always_comb begin
        cause_nxt = cause_r;
        dbg_nxt = dbg_r;
        dbg_act_nxt = dbg_act_r;
        if (pin_low) begin
            cause_nxt = pwrc_pkg::CAUSE_RESET; // [R16]
            dbg_nxt = pwrc_pkg::DBG_MODE_RESET; // [R8]
            dbg_act_nxt = 1'b0;
        end else begin
            if (i_cause_wr && !sys_rst_r) begin
                cause_nxt = cause_r & i_cause_wdata; // [R17]
            end
            if (wdt_entry) begin
                // Set after the clear so a coincident write loses.
                cause_nxt[pwrc_pkg::WDT_CAUSE_BIT] = 1'b1; // [R16] [R17]
            end
            if (i_dbg_wr && !sys_rst_r) begin
                dbg_nxt = i_dbg_wdata; // [R9]
            end
            if (release_now) begin
                dbg_act_nxt = debug_reset_pin_sync_r[1] &&
                              dbg_r[pwrc_pkg::DBG_EN_BIT]; // [R10]
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            cause_r <= pwrc_pkg::CAUSE_RESET;
            dbg_r <= pwrc_pkg::DBG_MODE_RESET;
            dbg_act_r <= 1'b0;
        end else begin
            cause_r <= cause_nxt;
            dbg_r <= dbg_nxt;
            dbg_act_r <= dbg_act_nxt;
        end
    end

    assign o_ctrl = ctrl_r;
    assign o_ram = ram_r;
    assign o_reset_cause_flags = cause_r;
    assign o_debug_mode_select_reg = dbg_r;
    assign o_debug_mode_active = dbg_act_r;
    assign o_system_reset = sys_rst_r;

endmodule // pwrc_reset_ctrl

// file: test/pwrc_reset_ctrl_sva.sv
// Purpose: Port checker for the reset sequencer.
// Assumes: One clock domain.
// Notes: Bound to every instance of the sequencer.
`timescale 1ns/1ps
module pwrc_reset_ctrl_sva #(
    parameter int unsigned OSC_STAB_CYCLES = pwrc_pkg::OSC_STAB_CYC
) (
    // Watched ports.
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_reset_pin_n,
    input wire logic i_watchdog_reset_request,
    input wire logic i_watchdog_reset_mode,
    input wire logic i_cause_wr,
    input wire logic [7:0] i_cause_wdata,
    input wire pwrc_pkg::pwrc_ctrl_t o_ctrl,
    input wire logic [7:0] o_reset_cause_flags,
    input wire logic [7:0] o_debug_mode_select_reg,
    input wire logic o_system_reset
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    // Cycles since the system reset last dropped; wide enough for the
    // full stabilization count, not only the shortened one.
    logic [23:0] wait_r;
    logic [23:0] wait_nxt;
    always_comb begin
        wait_nxt = o_system_reset ? 24'h0 : wait_r + 24'h1;
    end
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) wait_r <= 24'h0;
        else wait_r <= wait_nxt;
    end
    property p_hold;
        o_system_reset |-> o_ctrl.cpu_reset && o_ctrl.periph_reset
            && o_ctrl.pins_hiz && !o_ctrl.periph_clk_en
            && !o_ctrl.int_osc_en && !o_ctrl.main_osc_en
            && !o_ctrl.cpu_core_clock_en;
    endproperty
    a_hold: assert property (p_hold) else $error("unit live");
    property p_clr;
        o_system_reset |-> o_ctrl.watchdog_unit_clear;
    endproperty
    a_clr: assert property (p_clr) else $error("wdt not clear");
    property p_div;
        o_system_reset |-> o_ctrl.cpu_div_sel == pwrc_pkg::CPU_DIV_RESET;
    endproperty
    a_div: assert property (p_div) else $error("bad divider");
    property p_pin;
        $fell(i_reset_pin_n) |-> ##3 o_system_reset
            && o_reset_cause_flags == 8'h00
            && o_debug_mode_select_reg == 8'h01;
    endproperty
    a_pin: assert property (p_pin) else $error("pin reset");
    property p_wdt;
        i_watchdog_reset_request && i_watchdog_reset_mode && i_reset_pin_n
            && !o_ctrl.cpu_reset |=> o_system_reset && !o_ctrl.main_osc_en
            && o_reset_cause_flags[4] && $stable(o_debug_mode_select_reg);
    endproperty
    a_wdt: assert property (p_wdt) else $error("wdt entry");
    property p_len;
        $rose(o_system_reset) && o_reset_cause_flags[4]
            |-> ##99 o_system_reset ##1 !o_system_reset;
    endproperty
    a_len: assert property (p_len) else $error("wdt length");
    property p_osc;
        $fell(o_system_reset) |-> o_ctrl.main_osc_en && o_ctrl.cpu_reset
            && o_ctrl.int_osc_en && !o_ctrl.watchdog_unit_clear;
    endproperty
    a_osc: assert property (p_osc) else $error("release");
    property p_stab;
        $fell(o_ctrl.cpu_reset) |-> o_ctrl.cpu_core_clock_en
            && o_ctrl.periph_clk_en && wait_r == OSC_STAB_CYCLES;
    endproperty
    a_stab: assert property (p_stab) else $error("stab wait");
    property p_cw;
        i_cause_wr && !o_system_reset && i_reset_pin_n
            && !(i_watchdog_reset_request && i_watchdog_reset_mode)
            |=> o_reset_cause_flags
            == ($past(o_reset_cause_flags) & $past(i_cause_wdata));
    endproperty
    a_cw: assert property (p_cw) else $error("cause write");
    c_pin: cover property ($fell(i_reset_pin_n));
    c_wdt: cover property ($rose(o_system_reset) && o_reset_cause_flags[4]);
    c_run: cover property ($fell(o_ctrl.cpu_reset));
endmodule // pwrc_reset_ctrl_sva
bind pwrc_reset_ctrl pwrc_reset_ctrl_sva #(
    .OSC_STAB_CYCLES(OSC_STAB_CYCLES)
) u_sva (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_reset_pin_n(i_reset_pin_n),
    .i_watchdog_reset_request(i_watchdog_reset_request),
    .i_watchdog_reset_mode(i_watchdog_reset_mode),
    .i_cause_wr(i_cause_wr),
    .i_cause_wdata(i_cause_wdata),
    .o_ctrl(o_ctrl),
    .o_reset_cause_flags(o_reset_cause_flags),
    .o_debug_mode_select_reg(o_debug_mode_select_reg),
    .o_system_reset(o_system_reset)
);

// file: test/pwrc_partner.sv
// Purpose: Reset pin circuit and watchdog model.
// Assumes: Watchdog counts the system clock.
// Notes: Overflow gives a one-cycle request, then the count wraps.
`timescale 1ns/1ps
module pwrc_partner #(
    parameter int unsigned WDT_LIMIT = 40
) (
    // Clock and bench controls.
    input wire logic i_clk_sys,
    input wire logic i_hold_pin,
    input wire logic i_wdt_run,
    input wire logic i_wdt_clear,
    // To the sequencer.
    output logic o_reset_pin_n,
    output logic o_wdt_req
);
    logic [15:0] cnt_r = 16'h0;
    always_ff @(posedge i_clk_sys) begin
        o_reset_pin_n <= !i_hold_pin;
        o_wdt_req <= 1'b0;
        if (i_wdt_clear) begin
            cnt_r <= 16'h0;
        end else if (i_wdt_run) begin
            cnt_r <= (cnt_r == WDT_LIMIT) ? 16'h0 : cnt_r + 16'h1;
            o_wdt_req <= (cnt_r == WDT_LIMIT);
        end
    end
endmodule // pwrc_partner

// file: test/testbench.sv
// Purpose: Self-checking bench for the reset sequencer.
// Assumes: Stabilization shortened to 20 cycles.
// Notes: Random data come from a fixed seed.
`timescale 1ns/1ps
module testbench;
    localparam int unsigned STAB = 20;
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic hold_pin = 1'b0;
    logic wdt_run = 1'b0;
    logic i_reset_pin_n;
    logic i_watchdog_reset_request;
    logic i_debug_reset_pin = 1'b0;
    logic i_power_on = 1'b0;
    logic i_watchdog_reset_mode = 1'b0;
    logic i_cpu_ram_access = 1'b0;
    logic i_cause_wr = 1'b0;
    logic [7:0] i_cause_wdata = 8'h00;
    logic i_dbg_wr = 1'b0;
    logic [7:0] i_dbg_wdata = 8'h00;
    pwrc_pkg::pwrc_ctrl_t o_ctrl;
    pwrc_pkg::pwrc_ram_t o_ram;
    logic [7:0] o_reset_cause_flags;
    logic [7:0] o_debug_mode_select_reg;
    logic o_debug_mode_active;
    logic o_system_reset;
    int errors = 0;
    int cmp_count = 0;
    int n;
    logic m;
    logic dv;
    logic [7:0] dbg_v;
    logic [7:0] cause_v;
    logic [7:0] exp_c = 8'h00;
    initial forever #10 i_clk_sys = ~i_clk_sys;
    pwrc_partner i_far (.i_clk_sys, .i_hold_pin(hold_pin),
        .i_wdt_run(wdt_run), .i_wdt_clear(o_ctrl.watchdog_unit_clear),
        .o_reset_pin_n(i_reset_pin_n), .o_wdt_req(i_watchdog_reset_request));
    pwrc_reset_ctrl #(.OSC_STAB_CYCLES(STAB)) i_dut (.i_clk_sys, .i_resetn,
        .i_reset_pin_n, .i_debug_reset_pin, .i_power_on,
        .i_watchdog_reset_request, .i_watchdog_reset_mode, .i_cpu_ram_access,
        .i_cause_wr, .i_cause_wdata, .i_dbg_wr, .i_dbg_wdata, .o_ctrl,
        .o_ram, .o_reset_cause_flags, .o_debug_mode_select_reg,
        .o_debug_mode_active, .o_system_reset);
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Want is {cpu_reset, system_reset}; the count is edges waited minus one.
    task automatic wait_for(logic [1:0] want, output int cyc);
        for (cyc = 0; cyc < 3000; cyc++) begin
            @(posedge i_clk_sys);
            #1;
            if ({o_ctrl.cpu_reset, o_system_reset} === want) return;
        end
        errors++;
        close_out();
    endtask
    task automatic sw(logic dbg, logic [7:0] v);
        @(posedge i_clk_sys);
        i_dbg_wr <= dbg;
        i_cause_wr <= !dbg;
        i_dbg_wdata <= v;
        i_cause_wdata <= v;
        @(posedge i_clk_sys);
        i_dbg_wr <= 1'b0;
        i_cause_wr <= 1'b0;
        @(posedge i_clk_sys);
        #1;
    endtask
    initial begin
        n = $urandom(32'h4853af76);
        repeat (4) @(posedge i_clk_sys);
        #1;
        chk("in_rst", {7'h0, o_system_reset}, 8'h01);
        chk("dbg0", o_debug_mode_select_reg, 8'h01);
        @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        wait_for(2'b00, n);
        chk("div", {5'h0, o_ctrl.cpu_div_sel}, 8'h03);
        for (int k = 0; k < 8; k++) begin
            m = (k < 2) ? k[0] : 1'($urandom());
            dv = 1'($urandom());
            dbg_v = 8'($urandom());
            sw(1'b1, dbg_v);
            @(posedge i_clk_sys);
            i_watchdog_reset_mode <= m;
            i_debug_reset_pin <= dv;
            wdt_run <= 1'b1;
            if (!m) begin
                repeat (60) @(posedge i_clk_sys);
                #1;
                chk("ignored", {7'h0, o_system_reset}, 8'h00);
            end else begin
                // A zero write held up to the overflow must lose to the set.
                i_cause_wr <= 1'b1;
                i_cause_wdata <= 8'h00;
                wait_for(2'b11, n);
                i_cause_wr <= 1'b0;
                exp_c = 8'h10;
                chk("c_wdt", o_reset_cause_flags, exp_c);
                chk("osc", {7'h0, o_ctrl.main_osc_en}, 8'h00);
                chk("dbg_kept", o_debug_mode_select_reg, dbg_v);
                wait_for(2'b10, n);
                chk("wdt_len", n[7:0], 8'h63);
                wait_for(2'b00, n);
                chk("stab", n[7:0], 8'(STAB - 1));
                chk("dbg_on", {7'h0, o_debug_mode_active},
                    {7'h0, dv & dbg_v[0]});
            end
            @(posedge i_clk_sys);
            wdt_run <= 1'b0;
            cause_v = 8'($urandom());
            sw(1'b0, cause_v);
            exp_c = exp_c & cause_v;
            chk("c_wr", o_reset_cause_flags, exp_c);
        end
        @(posedge i_clk_sys);
        i_power_on <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        #1;
        chk("ram_po", {6'h0, o_ram}, 8'h03);
        @(posedge i_clk_sys);
        i_power_on <= 1'b0;
        // The synchronised power-on flag must drain before the write.
        repeat (2) @(posedge i_clk_sys);
        sw(1'b1, 8'h00);
        chk("ram_ok", {6'h0, o_ram}, 8'h00);
        @(posedge i_clk_sys);
        i_cpu_ram_access <= 1'b1;
        i_debug_reset_pin <= 1'b1;
        hold_pin <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        #1;
        chk("pin_rst", {7'h0, o_system_reset}, 8'h01);
        chk("c_pin", o_reset_cause_flags, 8'h00);
        chk("dbg_pin", o_debug_mode_select_reg, 8'h01);
        chk("ram_col", {7'h0, o_ram.ram_undefined}, 8'h01);
        @(posedge i_clk_sys);
        hold_pin <= 1'b0;
        i_cpu_ram_access <= 1'b0;
        wait_for(2'b00, n);
        chk("rel", n[7:0], 8'(STAB + 3));
        chk("clk_on", {7'h0, o_ctrl.periph_clk_en}, 8'h01);
        chk("dbg_on", {7'h0, o_debug_mode_active}, 8'h01);
        close_out();
    end
endmodule // testbench
